// *** sadc_ctrl.sv ***
`timescale 1ns/1ps
module sadc_ctrl #(
  parameter int RES_W = sadc_pkg::RES_W,
  parameter int STEP_CYC = sadc_pkg::STEP_CYC,
  parameter int FIFO_DEPTH = sadc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Control pins
  input wire sadc_pkg::sadc_ctl_t ctl_in,
  // Analog side
  input wire logic comp_in,
  output logic hold_out,
  output logic [RES_W-1:0] dac_code_out,
  // Status and data pins
  output logic busy_n_out,
  output sadc_pkg::sadc_bus_t port_out,
  // Result stream
  output logic res_valid_out,
  input wire logic res_ready_in,
  output logic [RES_W-1:0] res_data_out
);
  import sadc_pkg::*;

  // ****************
  // State
  // ****************
  sadc_state_t state_reg;
  sadc_state_t state_next;
  logic strobe_prev_reg;
  logic busy_n_reg;
  logic hold_reg;
  logic [RES_W-1:0] latch_reg;
  logic [LEAD_W-1:0] lead_reg;
  logic [LEAD_W-1:0] lead_next;
  sadc_bus_t port_reg;
  sadc_bus_t port_next;
  logic [RES_W-1:0] sar_result;
  logic sar_done;
  logic fifo_ready;

  // ****************
  // Decode
  // ****************
  wire strobe_fall = strobe_prev_reg && !ctl_in.rd_conv;
  wire selected = !ctl_in.dev_select_n;
  wire start_ok = strobe_fall && selected && !ctl_in.upper_byte_select && busy_n_reg;
  wire read_en = ctl_in.rd_conv && busy_n_reg && selected;
  wire load_go = (state_reg == ST_LOAD) && fifo_ready;
  wire lead_done = (lead_reg == LEAD_W'(BUSY_LEAD_CYC - 1));
  // Upper byte: MSB nibble on both nibbles, middle lanes low
  wire [RES_W-1:0] upper_word = {latch_reg[RES_W-1 -: NIB_W], NIB_ZERO, latch_reg[RES_W-1 -: NIB_W]};
  wire [RES_W-1:0] pin_word = ctl_in.upper_byte_select ? upper_word : latch_reg;
  wire conv_next = (state_next == ST_CONV);

  // ****************
  // Sequencer
  // ****************
  // A full result FIFO stretches busy; a slow stream consumer costs throughput
  always_comb begin
    state_next = state_reg;
    lead_next = lead_reg;
    case (state_reg)
      ST_IDLE: begin
        lead_next = LEAD_RST;
        if (start_ok) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (fifo_ready) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        lead_next = lead_reg + LEAD_W'(1);
        if (lead_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    port_next.data = pin_word;
    port_next.oe = {RES_W{read_en}};
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      lead_reg <= LEAD_RST;
      strobe_prev_reg <= 1'b0;
      busy_n_reg <= 1'b1;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lead_reg <= lead_next;
      strobe_prev_reg <= ctl_in.rd_conv;
      busy_n_reg <= (state_next == ST_IDLE);
      hold_reg <= conv_next;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_reg <= WORD_RST;
      port_reg <= '0;
    end else begin
      port_reg <= port_next;
      if (load_go) begin
        latch_reg <= sar_result;
      end
    end
  end

  assign busy_n_out = busy_n_reg;
  assign hold_out = hold_reg;
  assign port_out = port_reg;

  // ****************
  // Converter core and result buffer
  // ****************
  sadc_sar #(
    .WIDTH(RES_W),
    .STEP_CYC(STEP_CYC)
  ) u_sar (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(start_ok),
    .comp_in(comp_in),
    .trial_out(dac_code_out),
    .result_out(sar_result),
    .done_out(sar_done)
  );

  sadc_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(state_reg == ST_LOAD),
    .in_ready_out(fifo_ready),
    .in_data_in(sar_result),
    .out_valid_out(res_valid_out),
    .out_ready_in(res_ready_in),
    .out_data_out(res_data_out)
  );

  // ****************
  // Check helpers
  // ****************
  // Busy-low length, frozen while a full FIFO stalls the load
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_MIN_CYC = RES_W * STEP_CYC;
  localparam int CNT_W = $clog2(CONV_MAX_CYC + 1);
  logic [CNT_W-1:0] busy_cnt_reg;
  wire stall = (state_reg == ST_LOAD) && !fifo_ready;
  wire [CNT_W-1:0] busy_cnt_next = busy_n_reg ? '0 : (stall ? busy_cnt_reg : busy_cnt_reg + CNT_W'(1));

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_cnt_reg <= '0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_start_edge: assert property (
    $fell(busy_n_out) |-> $past(strobe_prev_reg) && !$past(ctl_in.rd_conv))
    else $error("Busy fell without a strobe falling edge");

  chk_start_gate: assert property (
    strobe_fall && busy_n_reg && (ctl_in.dev_select_n || ctl_in.upper_byte_select)
      |=> busy_n_out && !hold_out)
    else $error("Gated strobe edge started a conversion");

  chk_hold_start: assert property (
    start_ok |=> hold_out && !busy_n_out)
    else $error("Accepted start did not hold the sample");

  chk_busy_span: assert property (
    !busy_n_out |-> (state_reg != ST_IDLE))
    else $error("Busy low with no conversion running");

  chk_float_busy: assert property (
    !busy_n_out |=> port_out.oe == '0)
    else $error("Data pins driven during conversion");

  chk_no_restart: assert property (
    $rose(hold_out) |-> hold_out [*8])
    else $error("Conversion aborted or restarted early");

  chk_read_enable: assert property (
    port_out.oe[0] |-> $past(ctl_in.rd_conv) && $past(busy_n_reg) && !$past(ctl_in.dev_select_n))
    else $error("Pins enabled without read conditions");

  chk_deselect_float: assert property (
    ctl_in.dev_select_n |=> port_out.oe == '0)
    else $error("Pins driven while deselected");

  chk_upper_byte: assert property (
    $past(ctl_in.upper_byte_select) |-> port_out.data[7:4] == NIB_ZERO
      && port_out.data[3:0] == $past(latch_reg[RES_W-1 -: NIB_W]))
    else $error("Upper byte lanes wrong");

  chk_data_hold: assert property (
    port_out.oe[0] && $fell(ctl_in.rd_conv) |-> port_out.data == $past(port_out.data))
    else $error("Old result lost at strobe edge");

  chk_busy_lead: assert property (
    $rose(busy_n_out) |-> $stable(latch_reg) && $past(state_reg) == ST_SETTLE)
    else $error("Busy rose before result settled");

  chk_sar_steps: assert property (
    $rose(hold_out) |-> ##[90:100] sar_done)
    else $error("Twelve decisions not finished in time");

  chk_track_early: assert property (
    sar_done |=> !hold_out && !busy_n_out)
    else $error("Track or busy wrong at completion");

  // Stall cycles are left out, so only the converter itself is timed
  chk_conv_max: assert property (
    busy_cnt_reg <= CNT_W'(CONV_MAX_CYC))
    else $error("Conversion longer than the maximum time");

  chk_conv_min: assert property (
    $rose(busy_n_out) |-> busy_cnt_reg >= CNT_W'(CONV_MIN_CYC))
    else $error("Busy low shorter than twelve decisions");

  chk_read_drive: assert property (
    $past(rst_n_in) && $past(ctl_in.rd_conv) && $past(busy_n_reg) && !$past(ctl_in.dev_select_n) |-> port_out.oe[0])
    else $error("Read conditions met but pins floating");

  chk_full_word: assert property (
    $past(rst_n_in) && !$past(ctl_in.upper_byte_select) |-> port_out.data == $past(latch_reg))
    else $error("Full word lanes wrong");

  chk_upper_nibble: assert property (
    $past(rst_n_in) && $past(ctl_in.upper_byte_select)
      |-> port_out.data[RES_W-1 -: NIB_W] == $past(latch_reg[RES_W-1 -: NIB_W]))
    else $error("Top nibble lanes wrong");

  chk_msb_first: assert property (
    $rose(hold_out) |-> dac_code_out == {1'b1, {(RES_W-1){1'b0}}})
    else $error("First trial is not the top bit");

  chk_start_idle: assert property (
    $rose(hold_out) |-> $past(busy_n_out))
    else $error("Conversion started while busy");

  chk_hold_busy: assert property (
    hold_out |-> !busy_n_out)
    else $error("Sample held outside a conversion");

  chk_latch_quiet: assert property (
    busy_n_out |-> $stable(latch_reg))
    else $error("Result latch moved while busy high");

  chk_busy_track: assert property (
    $rose(busy_n_out) |-> !$past(hold_out) && !hold_out)
    else $error("Still holding when busy rose");
endmodule

// *** sadc_pkg.sv ***
package sadc_pkg;
  // ****************
  // Sizes and timing
  // ****************
  localparam int RES_W = 12;
  localparam int NIB_W = 4;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TYP_NS = 2470;
  localparam int CONV_MAX_NS = 2700;
  localparam int CONV_TYP_CYC = CONV_TYP_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC = CONV_TYP_CYC / RES_W;
  localparam int BUSY_LEAD_NS = 25;
  localparam int BUSY_LEAD_RAW = (BUSY_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_LEAD_CYC = (BUSY_LEAD_RAW < 1) ? 1 : BUSY_LEAD_RAW;
  localparam int LEAD_W = 4;
  localparam int FIFO_DEPTH = 8;
  // ****************
  // Reset values
  // ****************
  localparam logic [RES_W-1:0] WORD_RST = 12'h000;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [LEAD_W-1:0] LEAD_RST = 4'h0;
  // ****************
  // Types
  // ****************
  typedef enum {ST_IDLE, ST_CONV, ST_LOAD, ST_SETTLE} sadc_state_t;
  typedef struct packed {
    logic dev_select_n;
    logic rd_conv;
    logic upper_byte_select;
  } sadc_ctl_t;
  typedef struct packed {
    logic [RES_W-1:0] data;
    logic [RES_W-1:0] oe;
  } sadc_bus_t;
endpackage

// *** sadc_fifo.sv ***
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_reg[AW-1:0]];
  // ****************
  // Storage
  // ****************
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule

// *** sadc_sar.sv ***
`timescale 1ns/1ps
module sadc_sar #(
  parameter int WIDTH = 12,
  parameter int STEP_CYC = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic comp_in,
  // Results
  output logic [WIDTH-1:0] trial_out,
  output logic [WIDTH-1:0] result_out,
  output logic done_out
);
  localparam int BW = $clog2(WIDTH);
  localparam int SW = $clog2(STEP_CYC + 1);
  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
  logic run_reg;
  logic done_reg;
  logic [BW-1:0] bit_reg;
  logic [SW-1:0] step_reg;
  logic [WIDTH-1:0] trial_reg;
  logic [WIDTH-1:0] result_reg;
  // Comparator high keeps the trial bit, giving offset binary
  wire [WIDTH-1:0] mask = ONE << bit_reg;
  wire [WIDTH-1:0] decided = comp_in ? trial_reg : (trial_reg & ~mask);
  wire step_last = (step_reg == SW'(STEP_CYC - 1));
  wire bit_last = (bit_reg == '0);
  assign trial_out = trial_reg;
  assign result_out = result_reg;
  assign done_out = done_reg;
  // ****************
  // Bit decisions
  // ****************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_reg <= 1'b0;
      done_reg <= 1'b0;
      bit_reg <= '0;
      step_reg <= '0;
      trial_reg <= '0;
      result_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (start_in && !run_reg) begin
        run_reg <= 1'b1;
        bit_reg <= BW'(WIDTH - 1);
        step_reg <= '0;
        trial_reg <= ONE << (WIDTH - 1);
      end else if (run_reg) begin
        step_reg <= step_last ? '0 : step_reg + SW'(1);
        if (step_last) begin
          trial_reg <= decided | (mask >> 1);
          bit_reg <= bit_reg - BW'(1);
          if (bit_last) begin
            run_reg <= 1'b0;
            done_reg <= 1'b1;
            result_reg <= decided;
          end
        end
      end
    end
  end
endmodule

// *** sadc_afe_model.sv ***
`timescale 1ns/1ps
// ****************
// Analog side model
// ****************
module sadc_afe_model (
  // Clock
  input wire logic clock_in,
  // From block
  input wire logic hold_in,
  input wire logic [sadc_pkg::RES_W-1:0] dac_code_in,
  // From bench
  input wire logic [sadc_pkg::RES_W-1:0] level_in,
  // To block
  output logic comp_out
);
  import sadc_pkg::*;
  logic [RES_W-1:0] held_reg;
  // Tracks while released, frozen once held
  always @(posedge clock_in) begin
    if (!hold_in) begin
      held_reg <= level_in;
    end
  end
  // Keep bit when input is at or above trial
  assign comp_out = (held_reg >= dac_code_in);
endmodule

// *** sadc_ctrl_bench.sv ***
`timescale 1ns/1ps
module sadc_ctrl_bench;
  import sadc_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clock_in;
  logic rst_n_in;
  sadc_ctl_t ctl;
  logic comp;
  logic hold;
  logic [RES_W-1:0] dac;
  logic [RES_W-1:0] level;
  logic busy_n;
  sadc_bus_t port;
  logic res_valid;
  logic res_ready;
  logic [RES_W-1:0] res_data;
  int err_total;
  int comparisons;
  logic [11:0] codes [4] = '{12'h800, 12'h7ff, 12'hfff, 12'h000};
  sadc_ctrl DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .ctl_in(ctl), .comp_in(comp), .hold_out(hold),
    .dac_code_out(dac), .busy_n_out(busy_n), .port_out(port), .res_valid_out(res_valid),
    .res_ready_in(res_ready), .res_data_out(res_data));
  sadc_afe_model afe (.clock_in(clock_in), .hold_in(hold), .dac_code_in(dac), .level_in(level), .comp_out(comp));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic step(input logic [2:0] c, input logic [11:0] lv);
    @(posedge clock_in);
    ctl <= sadc_ctl_t'(c);
    level <= lv;
    #1;
  endtask
  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n < 300) begin
      tick(1);
      n++;
    end
    check(12'(busy_n), 12'(lvl));
  endtask
  task automatic pop(input logic [11:0] exp);
    check(12'(res_valid), 12'h001);
    check(res_data, exp);
    @(posedge clock_in);
    res_ready <= 1'b1;
    @(posedge clock_in);
    res_ready <= 1'b0;
    #1;
  endtask
  // Stand-alone start, strobe back high mid conversion
  task automatic conv_mode(input logic [11:0] code);
    int n;
    step(3'h2, code);
    step(3'h0, code);
    wait_lvl(1'b0);
    check(12'(hold), 12'h001);
    check(dac, 12'h800);
    n = 1;
    while (busy_n === 1'b0 && n < 300) begin
      check(port.oe, 12'h000);
      // Strobe and select wiggles must not restart or abort
      step((n % 4 >= 2 && n < 8) ? 3'h0 : ((n == 9) ? 3'h6 : 3'h2), ~code);
      n++;
    end
    check(12'(n >= 97 && n <= 108), 12'h001);
    check(port.data, code);
    check(12'(hold), 12'h000);
    tick(2);
    check(port.oe, 12'hfff);
    check(port.data, code);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic upper_byte;
    conv_mode(12'ha5c);
    pop(12'ha5c);
    step(3'h3, 12'h000);
    tick(1);
    check(port.data, 12'ha0a);
    step(3'h1, 12'h000);
    tick(4);
    check(12'(busy_n), 12'h001);
    step(3'h3, 12'h000);
    step(3'h2, 12'h000);
    tick(4);
    check(12'(busy_n), 12'h001);
  endtask
  task automatic deselect;
    step(3'h6, 12'h000);
    tick(1);
    check(port.oe, 12'h000);
    step(3'h4, 12'h000);
    tick(4);
    check(12'(busy_n), 12'h001);
    step(3'h0, 12'h000);
    tick(4);
    check(12'(busy_n), 12'h001);
  endtask
  task automatic read_mode(input logic [11:0] prev, input logic [11:0] code);
    step(3'h2, code);
    tick(1);
    check(port.oe, 12'hfff);
    check(port.data, prev);
    step(3'h0, code);
    check(port.oe, 12'hfff);
    check(port.data, prev);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    tick(2);
    check(port.oe, 12'h000);
    step(3'h2, code);
    tick(1);
    check(port.data, code);
    pop(code);
  endtask
  // Fill the result buffer until the sequencer stalls, then drain
  task automatic fifo_fill;
    for (int i = 0; i < 8; i++) begin
      conv_mode(12'(i * 12'h111));
    end
    step(3'h0, 12'h999);
    wait_lvl(1'b0);
    tick(150);
    check(12'(busy_n), 12'h000);
    for (int i = 0; i < 8; i++) begin
      pop(12'(i * 12'h111));
    end
    wait_lvl(1'b1);
    tick(1);
    pop(12'h999);
    check(12'(res_valid), 12'h000);
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    #(25 * 20000);
    err_total++;
    stop_test();
  end
  initial begin
    err_total = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    ctl = sadc_ctl_t'(3'h2);
    level = 12'h000;
    res_ready = 1'b0;
    tick(4);
    check(12'(busy_n), 12'h001);
    check(port.oe, 12'h000);
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      conv_mode(codes[i]);
      pop(codes[i]);
    end
    upper_byte();
    deselect();
    read_mode(12'ha5c, 12'h3c5);
    fifo_fill();
    stop_test();
  end
endmodule
